// *** pmfm_regs.vh ***
// What this block does
// - Fiber bit set by signal detect high at reset release, or by software writing one.
// - Far-end fault pattern is 84 ones then one zero.
// - Each far-end fault burst sends the whole pattern at least three times.
// - Fault code only with fiber, enable set, signal lost or PLL unlocked, no loopback.
// - Fiber with degraded signal detect blocks received data and drops link.
// - Partner remote fault sets partner-ability and status remote-fault bits.
// - Advertisement remote-fault bit is only written and read back by software; no local fault sets it.
// - Drive-strength bit raises MII receive, collision, carrier and transmit clock drive.
// - Registers are 16 bits, numbered 0 to 31.
// - Port disable pin high refuses accesses; configuration pins take control.
// - Port disable pin low accepts reads and writes; configuration pins ignored.
// - Straps sampled at reset for forced mode, else negotiate or parallel detect.
// - Negotiating partner is met with fast link pulse bursts.
// - Non-negotiating partner: link pulses give 10 Mbps, idle symbols 100 Mbps.
// - 100 Mbps twisted pair sends MLT3 continuously, idle symbols outside frames.
// - 10 Mbps uses Manchester, idle line between frames, periodic link pulses.
// - MII speed follows the resolved link speed.
// - Receive decoder follows the selected line mode.
// - Only accesses carrying the strapped five-bit device address are answered.
`ifndef PMFM_REGS_VH
`define PMFM_REGS_VH
`define PMFM_REG_CTRL 5'h00
`define PMFM_REG_STAT 5'h01
`define PMFM_REG_ADV 5'h04
`define PMFM_REG_LPA 5'h05
`define PMFM_REG_CFG 5'h10
`define PMFM_REG_STAT2 5'h11
`define PMFM_REG_DRV 5'h1a
`define PMFM_CTRL_RESET 15
`define PMFM_CTRL_LOOP 14
`define PMFM_CTRL_SPEED 13
`define PMFM_CTRL_AN_EN 12
`define PMFM_CTRL_AN_RESTART 9
`define PMFM_CTRL_DUPLEX 8
`define PMFM_STAT_AN_DONE 5
`define PMFM_STAT_RFAULT 4
`define PMFM_STAT_LINK 2
`define PMFM_ADV_RFAULT 13
`define PMFM_ADV_100 8
`define PMFM_CFG_FIBER 0
`define PMFM_CFG_FAR_END_FAULT_PATTERN_EN 2
`define PMFM_DRV_HIGH 11
`define PMFM_ADV_RESET 16'h01e1
`define PMFM_STAT_FIXED 16'h7809
`define PMFM_FAR_END_FAULT_PATTERN_ONES 7'h54
`define PMFM_FAR_END_FAULT_PATTERN_REPS 2'h3
`define PMFM_CLK_KHZ 10000
`define PMFM_NLP_PERIOD_US 16000
`define PMFM_NLP_CYCLES (`PMFM_NLP_PERIOD_US * `PMFM_CLK_KHZ / 1000)
`endif

// *** pmfm_ctrl.v ***
`timescale 1ns/10ps
`include "pmfm_regs.vh"
module pmfm_ctrl #(
  parameter NLP_CYCLES = `PMFM_NLP_CYCLES
)
(
  input wire i_clk,
  input wire i_arst_n,
  input wire [4:0] i_addr,
  input wire [4:0] i_phy_addr,
  input wire [15:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [15:0] o_rdata,
  output reg o_rdata_oe,
  input wire i_mgmt_port_disable_pin,
  input wire [4:0] i_phy_addr_strap,
  input wire [2:0] i_cfg_pins,
  input wire i_signal_detect_input,
  input wire i_rx_pll_lock,
  input wire i_link_clk,
  input wire i_lp_link_pulse,
  input wire i_lp_idle_symbols,
  input wire i_lp_page_valid,
  input wire [15:0] i_lp_page,
  input wire i_tx_en,
  output reg [1:0] o_line_mode,
  output reg o_mii_speed100,
  output reg o_full_duplex,
  output reg o_link_up,
  output reg o_flp_tx,
  output reg o_idle_symbols_tx,
  output reg o_line_idle,
  output reg o_link_pulse,
  output reg o_fiber_rx_block,
  output reg o_far_end_fault_pattern_active,
  output reg o_far_end_fault_pattern_bit,
  output reg o_mii_drive_high
);

  // Line modes: 0 = 10BASE-T, 1 = 100BASE-TX, 2 = 100BASE-FX
  localparam [1:0] MODE_10T = 2'h0;
  localparam [1:0] MODE_100TX = 2'h1;
  localparam [1:0] MODE_100FX = 2'h2;
  localparam [5:0] S_INIT = 6'h01;
  localparam [5:0] S_NEG = 6'h02;
  localparam [5:0] S_FORCED = 6'h04;
  localparam [5:0] S_LINK10 = 6'h08;
  localparam [5:0] S_LINK100 = 6'h10;
  localparam [5:0] S_FIBER = 6'h20;
  localparam [17:0] NLP_LAST = NLP_CYCLES[17:0] - 18'h00001;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: first stage feeds only the second
  reg [9:0] sync1;
  reg [9:0] sync2;
  wire [9:0] pin_raw;
  assign pin_raw = {i_tx_en, i_lp_page_valid, i_lp_idle_symbols, i_lp_link_pulse, i_link_clk,
    i_rx_pll_lock, i_signal_detect_input, i_cfg_pins[2], i_cfg_pins[1], i_cfg_pins[0]};
  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      sync1 <= 10'h000;
      sync2 <= 10'h000;
    end
    else
    begin
      sync1 <= pin_raw;
      sync2 <= sync1;
    end
  end
  reg dis1;
  reg dis2;
  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      dis1 <= 1'b1;
      dis2 <= 1'b1;
    end
    else
    begin
      dis1 <= i_mgmt_port_disable_pin;
      dis2 <= dis1;
    end
  end
  wire [2:0] cfg_s = sync2[2:0];
  wire sd_ok = sync2[3];
  wire pll_ok = sync2[4];
  wire lclk_s = sync2[5];
  wire lp_pulse = sync2[6];
  wire lp_idle = sync2[7];
  wire page_v = sync2[8];
  wire tx_en_s = sync2[9];
  reg lclk_d;
  reg page_v_d;
  wire lclk_rise = lclk_s & ~lclk_d;
  wire page_take = page_v & ~page_v_d;

  ////////////////////////////////////////////////////////////////////////////
  // Strap capture on the third clock edge after release, once the synchronisers hold pin values
  reg [1:0] boot_cnt;
  reg straps_done;
  reg [2:0] strap_cfg;
  reg strap_fiber;
  reg [4:0] strap_addr;
  wire strap_now = ~straps_done & (boot_cnt == 2'h2);
  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      boot_cnt <= 2'h0;
      straps_done <= 1'b0;
      strap_cfg <= 3'h0;
      strap_fiber <= 1'b0;
      strap_addr <= 5'h00;
    end
    else if (!straps_done)
    begin
      boot_cnt <= boot_cnt + 2'h1;
      if (strap_now)
      begin
        straps_done <= 1'b1;
        strap_cfg <= cfg_s;
        strap_fiber <= sd_ok;
        strap_addr <= i_phy_addr_strap;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port
  reg loopback;
  reg ctl_speed;
  reg ctl_an_en;
  reg ctl_duplex;
  reg an_restart;
  reg [15:0] adv;
  reg [15:0] lp_ability;
  reg rfault;
  reg fiber;
  reg far_end_fault_pattern_en;
  reg drv_high;
  reg an_done;
  reg [5:0] state;
  reg [5:0] next_state;
  // Pin disable refuses access entirely; device address must match the strap
  wire acc_ok = ~dis2 & straps_done & (i_phy_addr == strap_addr);
  wire wr_ok = i_wr & acc_ok;
  wire rd_ok = i_rd & acc_ok;
  wire rd_stat = rd_ok & (i_addr == `PMFM_REG_STAT);
  wire soft_rst = wr_ok & (i_addr == `PMFM_REG_CTRL) & i_wdata[`PMFM_CTRL_RESET];
  wire rf_set = page_take & (state == S_NEG) & i_lp_page[`PMFM_ADV_RFAULT];
  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      loopback <= 1'b0;
      ctl_speed <= 1'b0;
      ctl_an_en <= 1'b0;
      ctl_duplex <= 1'b0;
      an_restart <= 1'b0;
      adv <= `PMFM_ADV_RESET;
      fiber <= 1'b0;
      far_end_fault_pattern_en <= 1'b0;
      drv_high <= 1'b0;
      rfault <= 1'b0;
    end
    else
    begin
      an_restart <= 1'b0;
      if (strap_now)
      begin
        ctl_an_en <= cfg_s[2];
        ctl_speed <= cfg_s[1];
        ctl_duplex <= cfg_s[0];
        fiber <= sd_ok;
      end
      else if (soft_rst)
      begin
        // Soft reset returns to the values caught at the last hardware reset
        ctl_an_en <= strap_cfg[2];
        ctl_speed <= strap_cfg[1];
        ctl_duplex <= strap_cfg[0];
        fiber <= strap_fiber;
        loopback <= 1'b0;
        an_restart <= 1'b1;
      end
      else if (wr_ok)
      begin
        case (i_addr)
          `PMFM_REG_CTRL:
          begin
            loopback <= i_wdata[`PMFM_CTRL_LOOP];
            ctl_speed <= i_wdata[`PMFM_CTRL_SPEED];
            ctl_an_en <= i_wdata[`PMFM_CTRL_AN_EN];
            ctl_duplex <= i_wdata[`PMFM_CTRL_DUPLEX];
            an_restart <= i_wdata[`PMFM_CTRL_AN_RESTART];
          end
          `PMFM_REG_ADV: adv <= i_wdata;
          `PMFM_REG_CFG:
          begin
            fiber <= i_wdata[`PMFM_CFG_FIBER];
            far_end_fault_pattern_en <= i_wdata[`PMFM_CFG_FAR_END_FAULT_PATTERN_EN];
          end
          `PMFM_REG_DRV: drv_high <= i_wdata[`PMFM_DRV_HIGH];
          default: adv <= adv;
        endcase
      end
      // Latched until status is read; a new fault in the read cycle wins
      if (rf_set)
        rfault <= 1'b1;
      else if (rd_stat)
        rfault <= 1'b0;
    end
  end

  // Read answer stands for one cycle; undriven when refused
  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_rdata <= 16'h0000;
      o_rdata_oe <= 1'b0;
    end
    else
    begin
      o_rdata_oe <= rd_ok;
      o_rdata <= 16'h0000;
      if (rd_ok)
      begin
        case (i_addr)
          `PMFM_REG_CTRL: o_rdata <= {1'b0, loopback, ctl_speed, ctl_an_en, 3'h0,
            ctl_duplex, 8'h00};
          `PMFM_REG_STAT: o_rdata <= `PMFM_STAT_FIXED | {10'h000, an_done, rfault, 1'b0,
            o_link_up, 2'h0};
          `PMFM_REG_ADV: o_rdata <= adv;
          `PMFM_REG_LPA: o_rdata <= lp_ability;
          `PMFM_REG_CFG: o_rdata <= {13'h0000, far_end_fault_pattern_en, 1'b0, fiber};
          `PMFM_REG_STAT2: o_rdata <= {1'b0, o_mii_speed100, 3'h0, o_link_up,
            o_full_duplex, 1'b0, an_done, 5'h00, o_line_mode};
          `PMFM_REG_DRV: o_rdata <= {4'h0, drv_high, 11'h000};
          default: o_rdata <= 16'h0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operating mode resolution
  // Pins rule while management is disabled, registers otherwise
  wire eff_an = dis2 ? strap_cfg[2] : ctl_an_en;
  wire eff_speed = dis2 ? strap_cfg[1] : ctl_speed;
  wire eff_duplex = dis2 ? strap_cfg[0] : ctl_duplex;
  wire eff_fiber = dis2 ? strap_fiber : fiber;
  wire fx_link = sd_ok & pll_ok;
  reg res_speed;
  reg res_duplex;
  reg next_speed;
  reg next_duplex;
  always @*
  begin
    next_state = state;
    next_speed = res_speed;
    next_duplex = res_duplex;
    case (state)
      S_INIT:
        if (straps_done)
          next_state = eff_fiber ? S_FIBER : (eff_an ? S_NEG : S_FORCED);
      S_NEG:
        if (page_take)
        begin
          next_speed = adv[`PMFM_ADV_100] & i_lp_page[`PMFM_ADV_100];
          next_duplex = adv[6 + {2'h0, next_speed} + {2'h0, next_speed}]
            & i_lp_page[6 + {2'h0, next_speed} + {2'h0, next_speed}];
          next_state = next_speed ? S_LINK100 : S_LINK10;
        end
        else if (lp_idle)
        begin
          next_speed = 1'b1;
          next_duplex = 1'b0;
          next_state = S_LINK100;
        end
        else if (lp_pulse)
        begin
          next_speed = 1'b0;
          next_duplex = 1'b0;
          next_state = S_LINK10;
        end
      S_FORCED:
      begin
        next_speed = eff_speed;
        next_duplex = eff_duplex;
        next_state = eff_speed ? S_LINK100 : S_LINK10;
      end
      S_LINK10:
        if (!lp_pulse)
          next_state = S_INIT;
      S_LINK100:
        if (!lp_idle)
          next_state = S_INIT;
      S_FIBER:
      begin
        next_speed = 1'b1;
        next_duplex = eff_duplex;
      end
      default: next_state = S_INIT;
    endcase
    // Fiber mode changes and restarts always begin again from strap resolution
    if (an_restart || (state != S_INIT && (eff_fiber != (state == S_FIBER))))
      next_state = S_INIT;
  end

  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state <= S_INIT;
      res_speed <= 1'b0;
      res_duplex <= 1'b0;
      an_done <= 1'b0;
      lp_ability <= 16'h0000;
      lclk_d <= 1'b0;
      page_v_d <= 1'b0;
    end
    else
    begin
      state <= next_state;
      res_speed <= next_speed;
      res_duplex <= next_duplex;
      lclk_d <= lclk_s;
      page_v_d <= page_v;
      if (next_state == S_NEG || next_state == S_INIT)
        an_done <= 1'b0;
      else if (state == S_NEG)
        an_done <= 1'b1;
      if (state == S_NEG && page_take)
        lp_ability <= i_lp_page;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Normal link pulse timer for 10 Mbps
  reg [17:0] nlp_cnt;
  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      nlp_cnt <= 18'h00000;
    else if (state != S_LINK10 || nlp_cnt == NLP_LAST)
      nlp_cnt <= 18'h00000;
    else
      nlp_cnt <= nlp_cnt + 18'h00001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Far-end fault generator, one bit per link clock rising edge
  reg [6:0] far_end_fault_pattern_bit;
  reg [1:0] far_end_fault_pattern_reps;
  wire far_end_fault_pattern_cond = eff_fiber & far_end_fault_pattern_en & (~sd_ok | ~pll_ok) & ~loopback;
  wire far_end_fault_pattern_last = (far_end_fault_pattern_bit == `PMFM_FAR_END_FAULT_PATTERN_ONES);
  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      far_end_fault_pattern_bit <= 7'h00;
      far_end_fault_pattern_reps <= 2'h0;
      o_far_end_fault_pattern_active <= 1'b0;
      o_far_end_fault_pattern_bit <= 1'b0;
    end
    else if (lclk_rise)
    begin
      if (!o_far_end_fault_pattern_active)
      begin
        if (far_end_fault_pattern_cond)
        begin
          o_far_end_fault_pattern_active <= 1'b1;
          o_far_end_fault_pattern_bit <= 1'b1;
          far_end_fault_pattern_bit <= 7'h00;
          far_end_fault_pattern_reps <= 2'h0;
        end
      end
      else if (far_end_fault_pattern_last)
      begin
        // Stop only at a pattern boundary after the third copy
        if (far_end_fault_pattern_reps != 2'h3)
          far_end_fault_pattern_reps <= far_end_fault_pattern_reps + 2'h1;
        if ((far_end_fault_pattern_reps + 2'h1 >= `PMFM_FAR_END_FAULT_PATTERN_REPS || far_end_fault_pattern_reps == 2'h3) && !far_end_fault_pattern_cond)
        begin
          o_far_end_fault_pattern_active <= 1'b0;
          o_far_end_fault_pattern_bit <= 1'b0;
        end
        else
          o_far_end_fault_pattern_bit <= 1'b1;
        far_end_fault_pattern_bit <= 7'h00;
      end
      else
      begin
        far_end_fault_pattern_bit <= far_end_fault_pattern_bit + 7'h01;
        o_far_end_fault_pattern_bit <= (far_end_fault_pattern_bit + 7'h01 != `PMFM_FAR_END_FAULT_PATTERN_ONES);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered line and MII controls
  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_line_mode <= MODE_10T;
      o_mii_speed100 <= 1'b0;
      o_full_duplex <= 1'b0;
      o_link_up <= 1'b0;
      o_flp_tx <= 1'b0;
      o_idle_symbols_tx <= 1'b0;
      o_line_idle <= 1'b1;
      o_link_pulse <= 1'b0;
      o_fiber_rx_block <= 1'b0;
      o_mii_drive_high <= 1'b0;
    end
    else
    begin
      o_line_mode <= (state == S_FIBER) ? MODE_100FX : (res_speed ? MODE_100TX : MODE_10T);
      // Fiber is always 100 Mbps, so speed never trails the fiber link indication
      o_mii_speed100 <= res_speed | (state == S_FIBER);
      o_full_duplex <= res_duplex;
      o_link_up <= (state == S_FIBER) ? fx_link : (state == S_LINK10 || state == S_LINK100);
      o_flp_tx <= (state == S_NEG);
      o_idle_symbols_tx <= (state == S_LINK100) & ~tx_en_s;
      o_line_idle <= (state != S_LINK100) & (state != S_FIBER) & ~tx_en_s;
      o_link_pulse <= (state == S_LINK10) & (nlp_cnt == NLP_LAST) & ~tx_en_s;
      o_fiber_rx_block <= (state == S_FIBER) & ~sd_ok;
      o_mii_drive_high <= drv_high;
    end
  end

endmodule // pmfm_ctrl

// *** pmfm_link_partner.sv ***
`timescale 1ns/10ps
module pmfm_link_partner (
  input wire logic [1:0] i_kind,
  input wire logic i_rfault,
  input wire logic i_sig_good,
  output logic o_link_clk,
  output logic o_link_pulse,
  output logic o_idle,
  output logic o_page_valid,
  output logic [15:0] o_page,
  output logic o_signal_detect,
  output logic o_pll_lock
);
  // Line clock runs free, period eight system clocks, each edge 87 ns after a system clock rise
  initial
  begin
    o_link_clk = 1'b0;
    #137;
    forever #400 o_link_clk = ~o_link_clk;
  end
  initial o_page_valid = 1'b0;
  assign o_link_pulse = (i_kind == 2'h2);
  // A negotiating partner falls back to idle symbols once its page has gone out
  assign o_idle = (i_kind == 2'h3) | ((i_kind == 2'h1) & o_page_valid);
  assign o_signal_detect = i_sig_good;
  assign o_pll_lock = i_sig_good;
  assign o_page = {2'b00, i_rfault, 13'h0101};
  // Page settles well before the valid edge, so it is never caught mid-change
  always @(i_kind or i_rfault)
  begin
    o_page_valid = 1'b0;
    #200 o_page_valid = (i_kind == 2'h1);
  end
endmodule // pmfm_link_partner

// *** pmfm_ctrl_assertions.sv ***
`timescale 1ns/10ps
module pmfm_ctrl_assertions #(
  parameter NLP_CYCLES = 50
)
(
  input wire i_clk,
  input wire i_arst_n,
  input wire [4:0] i_addr,
  input wire [4:0] i_phy_addr,
  input wire [4:0] i_phy_addr_strap,
  input wire i_wr,
  input wire i_rd,
  input wire [15:0] o_rdata,
  input wire o_rdata_oe,
  input wire i_mgmt_port_disable_pin,
  input wire i_signal_detect_input,
  input wire i_rx_pll_lock,
  input wire i_link_clk,
  input wire [1:0] o_line_mode,
  input wire o_mii_speed100,
  input wire o_link_up,
  input wire o_idle_symbols_tx,
  input wire o_link_pulse,
  input wire o_fiber_rx_block,
  input wire o_far_end_fault_pattern_active,
  input wire o_far_end_fault_pattern_bit,
  input wire o_mii_drive_high
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  wire fe_bit = o_far_end_fault_pattern_bit;
  wire fe_act = o_far_end_fault_pattern_active;
  reg lk_q, bit_q, act_q, pls_seen;
  integer ones, zeros, pls_gap;
  ////////////////////////////////////////////////////////////////////////////////
  // Raw link clock rises are counted; the design's extra sync lag cancels per copy
  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      lk_q <= 1'b0;
      bit_q <= 1'b0;
      act_q <= 1'b0;
      pls_seen <= 1'b0;
      ones <= 0;
      zeros <= 0;
      pls_gap <= 0;
    end
    else
    begin
      lk_q <= i_link_clk;
      bit_q <= fe_bit;
      act_q <= fe_act;
      if (fe_bit && !bit_q)
        ones <= 0;
      else if (i_link_clk && !lk_q)
        ones <= ones + 1;
      if (fe_act && !act_q)
        zeros <= 0;
      else if (!fe_bit && bit_q && fe_act)
        zeros <= zeros + 1;
      pls_gap <= o_link_pulse ? 1 : pls_gap + 1;
      if (o_link_pulse)
        pls_seen <= 1'b1;
    end
  end
  sequence s_port_off;
    i_mgmt_port_disable_pin [*4];
  endsequence
  sequence s_copy_end;
    $fell(fe_bit) ##0 fe_act;
  endsequence
  read_after_strobe_a: assert property (o_rdata_oe |-> $past(i_rd) &&
    $past(i_phy_addr) == $past(i_phy_addr_strap)) else $error("read data without read");
  idle_rdata_zero_a: assert property (!o_rdata_oe |-> o_rdata == 16'h0000)
    else $error("read data not zero when undriven");
  port_off_refuse_a: assert property (s_port_off ##0 i_rd |=> !o_rdata_oe)
    else $error("read answered with port disabled");
  addr_mismatch_a: assert property (i_rd && i_phy_addr != i_phy_addr_strap |=>
    !o_rdata_oe) else $error("read answered for other address");
  drive_by_write_a: assert property ($changed(o_mii_drive_high) |-> $past(i_wr, 2) &&
    $past(i_addr, 2) == 5'h1a) else $error("drive strength changed without write");
  fiber_block_a: assert property (o_fiber_rx_block |-> !o_link_up &&
    o_line_mode == 2'h2) else $error("fiber block with link up");
  // The start decision used pin values from three edges back, through the synchronisers
  fault_start_a: assert property ($rose(fe_act) |-> o_line_mode == 2'h2 &&
    !($past(i_signal_detect_input, 3) && $past(i_rx_pll_lock, 3)))
    else $error("fault pattern started wrongly");
  fault_ones_a: assert property (s_copy_end |-> ones == 84)
    else $error("fault copy ones count wrong");
  fault_copies_a: assert property ($fell(fe_act) |-> zeros >= 3)
    else $error("fewer than three fault copies");
  speed_match_a: assert property (o_link_up |-> o_mii_speed100 == (o_line_mode != 2'h0))
    else $error("speed does not match line mode");
  idle_sym_mode_a: assert property (o_idle_symbols_tx |-> o_line_mode == 2'h1 && o_link_up)
    else $error("idle symbols outside fast link");
  pulse_gap_a: assert property (o_link_pulse && pls_seen |-> pls_gap >= NLP_CYCLES)
    else $error("link pulses too close");
endmodule // pmfm_ctrl_assertions
bind pmfm_ctrl pmfm_ctrl_assertions #(.NLP_CYCLES(NLP_CYCLES)) u_chk (.*);

// *** pmfm_ctrl_tb.sv ***
`timescale 1ns/10ps
module pmfm_ctrl_tb;
  typedef struct packed
  {
    logic w;
    logic [4:0] a;
    logic [15:0] d;
  } pmfm_row_t;
  logic i_clk = 0, i_arst_n = 0, i_wr = 0, i_rd = 0, i_tx_en = 0, i_mgmt_port_disable_pin = 0;
  logic [4:0] i_addr = 5'h00, i_phy_addr = 5'h05, i_phy_addr_strap = 5'h05;
  logic [15:0] i_wdata = 16'h0000, o_rdata, rdata_q;
  logic [2:0] i_cfg_pins = 3'h4;
  logic [1:0] o_line_mode, kind = 2'h0;
  logic o_rdata_oe, o_mii_speed100, o_full_duplex, o_link_up, o_flp_tx, o_idle_symbols_tx;
  logic o_line_idle, o_link_pulse, o_fiber_rx_block, o_far_end_fault_pattern_active;
  logic o_far_end_fault_pattern_bit, o_mii_drive_high, oe_q, rfault = 0, sig_good = 0;
  wire i_signal_detect_input, i_rx_pll_lock, i_link_clk, i_lp_link_pulse, i_lp_idle_symbols;
  wire i_lp_page_valid;
  wire [15:0] i_lp_page;
  int error_cnt = 0, checks = 0, cyc = 0, n, cnt;
  pmfm_row_t rows [6] = '{
    {1'b0, 5'h04, 16'h01e1},
    {1'b1, 5'h04, 16'h21e1},
    {1'b0, 5'h04, 16'h21e1},
    {1'b1, 5'h1f, 16'hffff},
    {1'b0, 5'h1f, 16'h0000},
    {1'b0, 5'h01, 16'h7809}
  };
  pmfm_ctrl #(.NLP_CYCLES(50)) dut (.*);
  pmfm_link_partner u_lp (.i_kind(kind), .i_rfault(rfault), .i_sig_good(sig_good),
    .o_link_clk(i_link_clk), .o_link_pulse(i_lp_link_pulse), .o_idle(i_lp_idle_symbols),
    .o_page_valid(i_lp_page_valid), .o_page(i_lp_page),
    .o_signal_detect(i_signal_detect_input), .o_pll_lock(i_rx_pll_lock));
  ////////////////////////////////////////////////////////////////////////////////
  always #50 i_clk = ~i_clk;
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      $display("mismatch at %0t: timeout", $time);
      finish_test;
    end
  end
  task finish_test;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Sample 1 ns after the edge so that edge's register updates have landed
  task tick;
    @(posedge i_clk);
    #1;
  endtask
  task wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task rd(input logic [4:0] a);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    rdata_q = o_rdata;
    oe_q = o_rdata_oe;
  endtask
  task do_reset(input logic sd);
    i_arst_n <= 1'b0;
    kind <= 2'h0;
    sig_good <= sd;
    repeat (2) @(posedge i_clk);
    i_arst_n <= 1'b1;
    repeat (5) tick;
  endtask
  task wait_link;
    int k;
    k = 0;
    while (o_link_up !== 1'b1 && k < 500)
    begin
      tick;
      k++;
    end
    chk(o_link_up, 1'b1);
  endtask
  initial
  begin
    tick;
    chk(o_line_idle, 1'b1);
    do_reset(1'b0);
    chk(o_flp_tx, 1'b1);
    foreach (rows[i])
    begin
      if (rows[i].w)
        wr(rows[i].a, rows[i].d);
      else
      begin
        rd(rows[i].a);
        chk(rdata_q, rows[i].d);
        chk(oe_q, 1'b1);
      end
    end
    wr(5'h1a, 16'h0800);
    repeat (2) tick;
    chk(o_mii_drive_high, 1'b1);
    wr(5'h1a, 16'h0000);
    repeat (2) tick;
    chk(o_mii_drive_high, 1'b0);
    i_phy_addr <= 5'h06;
    wr(5'h04, 16'h0000);
    rd(5'h04);
    chk(oe_q, 1'b0);
    chk(rdata_q, 16'h0000);
    i_phy_addr <= 5'h05;
    rd(5'h04);
    chk(rdata_q, 16'h21e1);
    i_mgmt_port_disable_pin <= 1'b1;
    repeat (4) tick;
    wr(5'h04, 16'h0000);
    rd(5'h04);
    chk(oe_q, 1'b0);
    i_mgmt_port_disable_pin <= 1'b0;
    repeat (4) tick;
    rd(5'h04);
    chk(rdata_q, 16'h21e1);
    rfault <= 1'b1;
    kind <= 2'h1;
    wait_link;
    chk(o_line_mode, 2'h1);
    chk(o_mii_speed100, 1'b1);
    chk(o_flp_tx, 1'b0);
    chk(o_full_duplex, 1'b1);
    rd(5'h05);
    chk(rdata_q, 16'h2101);
    rd(5'h01);
    chk(rdata_q[4], 1'b1);
    chk(o_idle_symbols_tx, 1'b1);
    i_tx_en <= 1'b1;
    repeat (4) tick;
    chk(o_idle_symbols_tx, 1'b0);
    i_tx_en <= 1'b0;
    for (n = 2; n < 4; n++)
    begin
      do_reset(1'b0);
      kind <= n[1:0];
      wait_link;
      chk(o_line_mode, 16'(n - 2));
      chk(o_mii_speed100, 16'(n - 2));
      chk(o_full_duplex, 1'b0);
      cnt = 0;
      repeat (120)
      begin
        tick;
        cnt += o_link_pulse;
      end
      chk(cnt != 0, n == 2);
      chk(o_line_idle, n == 2);
    end
    i_cfg_pins <= 3'h3;
    do_reset(1'b0);
    repeat (2) tick;
    chk(o_line_mode, 2'h1);
    chk(o_full_duplex, 1'b1);
    i_cfg_pins <= 3'h4;
    do_reset(1'b0);
    wr(5'h10, 16'h0001);
    repeat (3) tick;
    chk(o_line_mode, 2'h2);
    chk(o_fiber_rx_block, 1'b1);
    repeat (100) tick;
    chk(o_far_end_fault_pattern_active, 1'b0);
    wr(5'h10, 16'h0005);
    n = 0;
    while (o_far_end_fault_pattern_active !== 1'b1 && n < 40)
    begin
      tick;
      n++;
    end
    chk(o_far_end_fault_pattern_active, 1'b1);
    sig_good <= 1'b1;
    cnt = 0;
    while (o_far_end_fault_pattern_bit === 1'b1 && cnt < 2000)
    begin
      tick;
      cnt++;
    end
    chk(cnt, 672);
    while (o_far_end_fault_pattern_active === 1'b1 && cnt < 4000)
    begin
      tick;
      cnt++;
    end
    chk(cnt >= 2040 && cnt <= 2048, 1'b1);
    wr(5'h00, 16'h4000);
    sig_good <= 1'b0;
    repeat (200) tick;
    chk(o_far_end_fault_pattern_active, 1'b0);
    do_reset(1'b1);
    chk(o_line_mode, 2'h2);
    wait_link;
    chk(o_fiber_rx_block, 1'b0);
    finish_test;
  end
endmodule // pmfm_ctrl_tb
